// File: verilog/tbirq_pkg.sv
// Constants for the thermal and power-button interrupt register slice.
// Assumes a 100 MHz reference clock and 8-bit registers on a byte address.
package tbirq_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] THERM_STAT_ADDR  = 8'h20; // Thermal event status
   localparam logic [7:0] THERM_MASK_ADDR  = 8'h21; // Thermal event mask
   localparam logic [7:0] THERM_SENSE_ADDR = 8'h22; // Thermal live levels
   localparam logic [7:0] BTN_STAT_ADDR    = 8'h24; // Button event status
   localparam logic [7:0] BTN_MASK_ADDR    = 8'h25; // Button event mask
   localparam logic [7:0] BTN_SENSE_ADDR   = 8'h26; // Button live levels

   // ---------------------------------------------------------------
   // Field positions and used-bit masks
   // ---------------------------------------------------------------
   localparam int         HOT_LOW_BIT   = 0;      // 110 degree field
   localparam int         HOT_HIGH_BIT  = 2;      // 125 degree field
   localparam int         BTN_CHG_BIT   = 0;      // Button change field
   localparam int         BTN_HOLD_LSB  = 1;      // First hold field
   localparam logic [7:0] THERM_USED    = 8'h05;  // Bits 0 and 2
   localparam logic [7:0] BTN_USED      = 8'h3F;  // Bits 5 to 0

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] THERM_MASK_RST = 8'h05; // Both events masked
   localparam logic [7:0] BTN_MASK_RST   = 8'h3F; // All events masked
   localparam logic [7:0] STAT_RST       = 8'h00; // No events pending

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;        // 100 MHz
   localparam int unsigned MS_TICK_NS     = 1_000_000; // Timebase step
   localparam int unsigned MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned HOLD_COUNT     = 5;         // Hold events
   localparam int unsigned MS_PER_S       = 1000;
   localparam int unsigned HOLD_S [HOLD_COUNT] = '{1, 2, 3, 4, 8};

   // Debouncer states, Gray along idle-press-release-idle
   typedef enum logic [1:0] {
      BTN_IDLE     = 2'b00,
      BTN_FALL_DEB = 2'b01,
      BTN_PRESSED  = 2'b11,
      BTN_RISE_DEB = 2'b10
   } tbirq_btn_state_t;

endpackage

// File: verilog/tbirq_button.sv
// Power button debouncer and hold-duration timer.
// Assumes a synchronised active-high pressed input and a 1 ms tick pulse.
module tbirq_button #(
   parameter int unsigned DEB_W = 8
) (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_resetn,
   // Timebase and button
   input  wire logic             i_ms_tick,
   input  wire logic             i_button_low,
   input  wire logic [DEB_W-1:0] i_fall_deb_ms,
   input  wire logic [DEB_W-1:0] i_rise_deb_ms,
   // Results
   output logic                  o_button_pressed_level,
   output logic                  o_change_pulse,
   output logic [4:0]            o_hold_pulse,
   output logic [4:0]            o_hold_level
);

   // ---------------------------------------------------------------
   // Debounce state machine
   // ---------------------------------------------------------------
   tbirq_pkg::tbirq_btn_state_t state_reg;   // Debounce phase
   logic [DEB_W-1:0]            deb_cnt_reg; // Ticks seen this phase
   logic [13:0]                 hold_cnt_reg;// Milliseconds held
   logic                        fall_done;   // Press outlasted debounce
   logic                        rise_done;   // Release outlasted debounce

   // A phase ends after one tick more than the setting: strictly longer
   assign fall_done = (state_reg == tbirq_pkg::BTN_FALL_DEB) && i_ms_tick
                      && (deb_cnt_reg == i_fall_deb_ms);
   assign rise_done = (state_reg == tbirq_pkg::BTN_RISE_DEB) && i_ms_tick
                      && (deb_cnt_reg == i_rise_deb_ms);

   // Phase transitions
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg   <= tbirq_pkg::BTN_IDLE;
         deb_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            tbirq_pkg::BTN_IDLE: begin
               deb_cnt_reg <= '0;
               if (i_button_low) begin
                  state_reg <= tbirq_pkg::BTN_FALL_DEB;
               end
            end
            tbirq_pkg::BTN_FALL_DEB: begin
               // Bounce back high aborts the press
               if (!i_button_low) begin
                  state_reg <= tbirq_pkg::BTN_IDLE;
               end else if (fall_done) begin
                  state_reg   <= tbirq_pkg::BTN_PRESSED;
                  deb_cnt_reg <= '0;
               end else if (i_ms_tick) begin
                  deb_cnt_reg <= deb_cnt_reg + 1'b1;
               end
            end
            tbirq_pkg::BTN_PRESSED: begin
               deb_cnt_reg <= '0;
               if (!i_button_low) begin
                  state_reg <= tbirq_pkg::BTN_RISE_DEB;
               end
            end
            tbirq_pkg::BTN_RISE_DEB: begin
               // Release only counts once it outlasts its debounce
               if (i_button_low) begin
                  state_reg   <= tbirq_pkg::BTN_PRESSED;
                  deb_cnt_reg <= '0;
               end else if (rise_done) begin
                  state_reg <= tbirq_pkg::BTN_IDLE;
               end else if (i_ms_tick) begin
                  deb_cnt_reg <= deb_cnt_reg + 1'b1;
               end
            end
         endcase
      end
   end

   // Debounced level and its change pulse
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_button_pressed_level <= 1'b0;
         o_change_pulse         <= 1'b0;
      end else begin
         o_change_pulse <= fall_done || rise_done;
         if (fall_done) begin
            o_button_pressed_level <= 1'b1;
         end else if (rise_done) begin
            o_button_pressed_level <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Hold timer
   // ---------------------------------------------------------------
   // Counter saturates past the longest threshold to avoid re-firing
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold_cnt_reg <= '0;
         o_hold_pulse <= '0;
         o_hold_level <= '0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            o_hold_pulse[i] <= o_button_pressed_level && i_ms_tick
               && (hold_cnt_reg == 14'(tbirq_pkg::HOLD_S[i] * tbirq_pkg::MS_PER_S));
         end
         if (!o_button_pressed_level) begin
            hold_cnt_reg <= '0;        // Restart timing on every new press
            o_hold_level <= '0;
         end else begin
            o_hold_level <= o_hold_level | o_hold_pulse;
            if (i_ms_tick && hold_cnt_reg != 14'h3FFF) begin
               hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   hold_level_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $fell(o_button_pressed_level) |=> (o_hold_level == 5'h00))
      else $error("hold level survived release");

   change_pulse_pair_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $changed(o_button_pressed_level) |-> o_change_pulse)
      else $error("debounced change gave no pulse");

endmodule

// File: verilog/tbirq_regs.sv
// Thermal and power-button interrupt registers with active-low request.
// Assumes the serial control slave hands over byte reads and writes as
// single-cycle strobes on i_ref_clk; comparator and button pins are async.
module tbirq_regs #(
   parameter int unsigned P_MS_CYCLES = tbirq_pkg::MS_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_resetn,
   // Register access from the serial slave
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr_en,
   input  wire logic [7:0] i_reg_wr_data,
   input  wire logic       i_reg_rd_en,
   output logic      [7:0] o_reg_rd_data,
   // Analog comparators and button pin
   input  wire logic       i_die_above_110,
   input  wire logic       i_die_above_125,
   input  wire logic       i_power_button_n,
   // Debounce settings in milliseconds
   input  wire logic [7:0] i_fall_deb_ms,
   input  wire logic [7:0] i_rise_deb_ms,
   // Interrupt request
   output logic            o_irq_out_n
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int unsigned DIV_W = $clog2(P_MS_CYCLES);
   logic [DIV_W-1:0] div_reg;            // Millisecond divider
   logic             ms_tick;            // One-cycle 1 ms enable
   logic [2:0]       sync1_reg;          // First synchroniser stage
   logic [2:0]       sync2_reg;          // Second synchroniser stage
   logic             hot_low_prev_reg;   // Last 110 degree level
   logic             hot_high_prev_reg;  // Last 125 degree level
   logic [7:0]       therm_stat_reg;     // Thermal events
   logic [7:0]       therm_mask_reg;     // Thermal masks
   logic [7:0]       btn_stat_reg;       // Button events
   logic [7:0]       btn_mask_reg;       // Button masks
   logic [7:0]       therm_set;          // Thermal set this cycle
   logic [7:0]       btn_set;            // Button set this cycle
   logic [7:0]       therm_clr;          // Thermal clear this cycle
   logic [7:0]       btn_clr;            // Button clear this cycle
   logic [7:0]       therm_sense;        // Live thermal levels
   logic [7:0]       btn_sense;          // Live button levels
   logic             button_pressed_level;
   logic             change_pulse;
   logic [4:0]       hold_pulse;
   logic [4:0]       hold_level;
   logic             irq_pending;        // Any unmasked event

   // Sticky update: set wins, so an event racing its clear is kept
   function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                         input logic [7:0] clr, input logic [7:0] used);
      return ((cur & ~clr) | set) & used;
   endfunction

   // Clear request for one status address: read clears all, write 1s
   // Bus signals come in as arguments so a continuous assign re-evaluates on them
   function automatic logic [7:0] clr_of(input logic [7:0] addr, input logic rd,
                                         input logic wr, input logic [7:0] a,
                                         input logic [7:0] d);
      return (rd && a == addr) ? 8'hFF
           : (wr && a == addr) ? d : 8'h00;
   endfunction

   // ---------------------------------------------------------------
   // Timebase and pin synchronisers
   // ---------------------------------------------------------------
   assign ms_tick = (div_reg == DIV_W'(P_MS_CYCLES - 1));

   // Millisecond divider for debounce and hold timing
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_reg <= '0;
      end else begin
         div_reg <= ms_tick ? '0 : div_reg + 1'b1;
      end
   end

   // Two stages per async input; only stage two is read
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end else begin
         sync1_reg <= {!i_power_button_n, i_die_above_125, i_die_above_110};
         sync2_reg <= sync1_reg;
      end
   end

   // ---------------------------------------------------------------
   // Button debouncer and hold timer
   // ---------------------------------------------------------------
   tbirq_button #(
      .DEB_W (8)
   ) u_button (
      .i_ref_clk              (i_ref_clk),
      .i_resetn               (i_resetn),
      .i_ms_tick              (ms_tick),
      .i_button_low           (sync2_reg[2]),
      .i_fall_deb_ms          (i_fall_deb_ms),
      .i_rise_deb_ms          (i_rise_deb_ms),
      .o_button_pressed_level (button_pressed_level),
      .o_change_pulse         (change_pulse),
      .o_hold_pulse           (hold_pulse),
      .o_hold_level           (hold_level)
   );

   // ---------------------------------------------------------------
   // Event sources
   // ---------------------------------------------------------------
   // Thermal events fire on both rising and falling crossings
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hot_low_prev_reg  <= 1'b0;
         hot_high_prev_reg <= 1'b0;
      end else begin
         hot_low_prev_reg  <= sync2_reg[0];
         hot_high_prev_reg <= sync2_reg[1];
      end
   end

   always_comb begin
      therm_set                            = 8'h00;
      therm_set[tbirq_pkg::HOT_LOW_BIT]    = sync2_reg[0] ^ hot_low_prev_reg;
      therm_set[tbirq_pkg::HOT_HIGH_BIT]   = sync2_reg[1] ^ hot_high_prev_reg;
      btn_set                              = 8'h00;
      btn_set[tbirq_pkg::BTN_CHG_BIT]      = change_pulse;
      btn_set[tbirq_pkg::BTN_HOLD_LSB+:5]  = hold_pulse;
      therm_sense                          = 8'h00;
      therm_sense[tbirq_pkg::HOT_LOW_BIT]  = hot_low_prev_reg;
      therm_sense[tbirq_pkg::HOT_HIGH_BIT] = hot_high_prev_reg;
      btn_sense                            = {2'b00, hold_level, button_pressed_level};
   end

   assign therm_clr = clr_of(tbirq_pkg::THERM_STAT_ADDR, i_reg_rd_en, i_reg_wr_en,
                             i_reg_addr, i_reg_wr_data);
   assign btn_clr   = clr_of(tbirq_pkg::BTN_STAT_ADDR, i_reg_rd_en, i_reg_wr_en,
                             i_reg_addr, i_reg_wr_data);

   // ---------------------------------------------------------------
   // Status and mask registers
   // ---------------------------------------------------------------
   // Status bits: sticky, cleared by read or write 1
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         therm_stat_reg <= tbirq_pkg::STAT_RST;
         btn_stat_reg   <= tbirq_pkg::STAT_RST;
      end else begin
         therm_stat_reg <= sticky(therm_stat_reg, therm_set, therm_clr, tbirq_pkg::THERM_USED);
         btn_stat_reg   <= sticky(btn_stat_reg, btn_set, btn_clr, tbirq_pkg::BTN_USED);
      end
   end

   // Masks reset set, so nothing interrupts until software opts in
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         therm_mask_reg <= tbirq_pkg::THERM_MASK_RST;
         btn_mask_reg   <= tbirq_pkg::BTN_MASK_RST;
      end else if (i_reg_wr_en) begin
         if (i_reg_addr == tbirq_pkg::THERM_MASK_ADDR) begin
            therm_mask_reg <= i_reg_wr_data & tbirq_pkg::THERM_USED;
         end
         if (i_reg_addr == tbirq_pkg::BTN_MASK_ADDR) begin
            btn_mask_reg <= i_reg_wr_data & tbirq_pkg::BTN_USED;
         end
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rd_data <= 8'h00;
      end else if (i_reg_rd_en) begin
         unique case (i_reg_addr)
            tbirq_pkg::THERM_STAT_ADDR:  o_reg_rd_data <= therm_stat_reg;
            tbirq_pkg::THERM_MASK_ADDR:  o_reg_rd_data <= therm_mask_reg;
            tbirq_pkg::THERM_SENSE_ADDR: o_reg_rd_data <= therm_sense;
            tbirq_pkg::BTN_STAT_ADDR:    o_reg_rd_data <= btn_stat_reg;
            tbirq_pkg::BTN_MASK_ADDR:    o_reg_rd_data <= btn_mask_reg;
            tbirq_pkg::BTN_SENSE_ADDR:   o_reg_rd_data <= btn_sense;
            default:                     o_reg_rd_data <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupt output
   // ---------------------------------------------------------------
   assign irq_pending = |(therm_stat_reg & ~therm_mask_reg)
                      | |(btn_stat_reg & ~btn_mask_reg);

   // Registered so the pin never glitches on decode
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_irq_out_n <= 1'b1;
      end else begin
         o_irq_out_n <= !irq_pending;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence therm_write_s;
      i_reg_wr_en && i_reg_addr == tbirq_pkg::THERM_MASK_ADDR;
   endsequence

   irq_follows_pend_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      ##1 (o_irq_out_n == !$past(irq_pending)))
      else $error("interrupt pin does not follow pending events");

   mask_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      therm_write_s |=> therm_mask_reg == ($past(i_reg_wr_data) & 8'h05))
      else $error("thermal mask write lost");

   masked_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (therm_mask_reg == 8'h05 && btn_mask_reg == 8'h3F) [*2] |-> o_irq_out_n)
      else $error("interrupt while all masked");

   w1c_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_reg_wr_en && i_reg_addr == 8'h24 && btn_set == 8'h00)
      |=> (btn_stat_reg & $past(i_reg_wr_data)) == 8'h00)
      else $error("write one did not clear");

   w0_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_reg_wr_en && i_reg_addr == tbirq_pkg::BTN_STAT_ADDR && !i_reg_rd_en)
      |=> ($past(btn_stat_reg) & ~$past(i_reg_wr_data) & ~btn_stat_reg) == 8'h00)
      else $error("write zero changed a bit");

   read_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_reg_rd_en && i_reg_addr == 8'h20 && therm_set == 8'h00)
      |=> therm_stat_reg == 8'h00 && o_reg_rd_data == $past(therm_stat_reg))
      else $error("read did not return and clear");

   set_wins_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $changed(sync2_reg[0]) |=> therm_stat_reg[0])
      else $error("thermal crossing lost");

   sense_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_reg_rd_en && i_reg_addr == 8'h22) |=> o_reg_rd_data[2] == $past(hot_high_prev_reg)
      && o_reg_rd_data[7:3] == 5'h00)
      else $error("thermal sense read wrong");

   btn_event_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      change_pulse |=> btn_stat_reg[0])
      else $error("button change event lost");

endmodule

// File: tb/tbirq_host_model.sv
// Host model: byte reads and writes on the register strobe port.
// Assumes a free-running i_ref_clk; drives only on its falling edge.
module tbirq_host_model (
   // Clock
   input  wire logic       i_ref_clk,
   // Strobe bus toward the registers
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr_en,
   output logic      [7:0] o_reg_wr_data,
   output logic            o_reg_rd_en,
   input  wire logic [7:0] i_reg_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Idle bus
   // ---------------------------------------------------------------
   initial begin
      o_reg_addr    = 8'h00;
      o_reg_wr_en   = 1'b0;
      o_reg_wr_data = 8'h00;
      o_reg_rd_en   = 1'b0;
   end

   // ---------------------------------------------------------------
   // Transfers
   // ---------------------------------------------------------------
   // One-cycle write strobe; a 1 in a status bit clears it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_reg_addr    = a;
      o_reg_wr_data = d;
      o_reg_wr_en   = 1'b1;
      @(negedge i_ref_clk);
      o_reg_wr_en   = 1'b0;
      // Released lines never keep the last value
      o_reg_addr    = ~a;
      o_reg_wr_data = ~d;
   endtask

   // Read strobe; the data lands one edge later and reading clears status
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_ref_clk);
      o_reg_addr  = a;
      o_reg_rd_en = 1'b1;
      @(negedge i_ref_clk);
      o_reg_rd_en = 1'b0;
      o_reg_addr  = ~a;
      @(negedge i_ref_clk);
      d = i_reg_rd_data;
   endtask
endmodule

// File: tb/test_thermal_button_irq_regs.sv
// Bench for the thermal and button interrupt registers.
// Assumes a 4-cycle ms tick so that an 8 s hold fits in a short run.
module test_thermal_button_irq_regs;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int P_MS = 4;  // Cycles per ms tick
   logic       clk;          // Reference clock
   logic       resetn;       // Async reset, active low
   logic [7:0] addr;         // Register address
   logic       wr_en;        // Write strobe
   logic [7:0] wr_data;      // Write data
   logic       rd_en;        // Read strobe
   logic [7:0] rd_data;      // Read data
   logic       die_110;      // Comparator, above 110
   logic       die_125;      // Comparator, above 125
   logic       button_n;     // Button pin, low = pressed
   logic       irq_n;        // Interrupt, active low
   int         n_errors;     // Mismatches
   int         num_checks;   // Comparisons

   // ---------------------------------------------------------------
   // Design and host
   // ---------------------------------------------------------------
   tbirq_regs #(.P_MS_CYCLES(P_MS)) DUT (
      .i_ref_clk(clk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wr_en(wr_en),
      .i_reg_wr_data(wr_data), .i_reg_rd_en(rd_en), .o_reg_rd_data(rd_data),
      .i_die_above_110(die_110), .i_die_above_125(die_125),
      .i_power_button_n(button_n), .i_fall_deb_ms(8'h01), .i_rise_deb_ms(8'h01),
      .o_irq_out_n(irq_n));
   tbirq_host_model HOST (
      .i_ref_clk(clk), .o_reg_addr(addr), .o_reg_wr_en(wr_en),
      .o_reg_wr_data(wr_data), .o_reg_rd_en(rd_en), .i_reg_rd_data(rd_data));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Interrupt pin after its one-cycle lag has passed
   task automatic chk_irq(input logic exp);
      cyc(3);
      chk_byte({7'h00, irq_n}, {7'h00, exp});
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      HOST.rd(a, d);
      chk_byte(d, exp);
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Reset values, unused mask bits, unmapped address
   task automatic t_reset;
      rd_chk(8'h21, tbirq_pkg::THERM_MASK_RST);
      rd_chk(8'h22, 8'h00);
      rd_chk(8'h24, 8'h00);
      rd_chk(8'h30, 8'h00);
      HOST.wr(8'h21, 8'hFF);
      rd_chk(8'h21, 8'h05);
      chk_irq(1'b1);
   endtask
   // Both crossings, masking and both ways of clearing
   task automatic t_thermal;
      die_110 = 1'b1;
      cyc(10);
      rd_chk(8'h22, 8'h01);
      chk_irq(1'b1);
      HOST.wr(8'h21, 8'h00);
      chk_irq(1'b0);
      HOST.wr(8'h20, 8'h00);
      chk_irq(1'b0);
      HOST.wr(8'h20, 8'h01);
      chk_irq(1'b1);
      die_110 = 1'b0;
      cyc(10);
      chk_irq(1'b0);
      rd_chk(8'h20, 8'h01);
      chk_irq(1'b1);
      rd_chk(8'h20, 8'h00);
      die_125 = 1'b1;
      cyc(10);
      rd_chk(8'h22, 8'h04);
      rd_chk(8'h20, 8'h04);
      HOST.wr(8'h21, 8'h05);
   endtask
   // A bounce is ignored; a hold sets its hold events, release flags again
   task automatic t_press(input int ms);
      logic [7:0] e;
      e = 8'h01;
      for (int i = 0; i < 5; i++) begin
         if (ms > tbirq_pkg::HOLD_S[i] * 1000) e[i+1] = 1'b1;
      end
      button_n = 1'b0;
      cyc(3);
      button_n = 1'b1;
      cyc(6 * P_MS);
      rd_chk(8'h24, 8'h00);
      button_n = 1'b0;
      cyc(ms * P_MS);
      rd_chk(8'h26, e);
      rd_chk(8'h24, e);
      button_n = 1'b1;
      cyc(6 * P_MS);
      HOST.wr(8'h25, 8'h3E);
      chk_irq(1'b0);
      HOST.wr(8'h24, 8'h00);
      chk_irq(1'b0);
      HOST.wr(8'h24, 8'h01);
      chk_irq(1'b1);
      HOST.wr(8'h25, 8'h3F);
      rd_chk(8'h25, 8'h3F);
      rd_chk(8'h24, 8'h00);
      rd_chk(8'h26, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      n_errors = 0;
      num_checks = 0;
      resetn = 1'b0;
      die_110 = 1'b0;
      die_125 = 1'b0;
      button_n = 1'b1;
      cyc(5);
      resetn = 1'b1;
      t_reset();
      t_thermal();
      t_press(1500);
      t_press(8200);
      finish_test();
   end
   // Expected run is about 40000 cycles
   initial begin
      #600_000;
      n_errors++;
      finish_test();
   end
endmodule
